// >>> verif/opcode_timing_and_program_map_tb.sv
// Testbench for the opcode timing sequencer and address checker.
// Assumes the program store model drives the whole fetch side.
`timescale 1ns/100ps
module opcode_timing_and_program_map_tb;
   import opcode_map_pkg::*;
   logic clk_in, rst_in, fetch_valid, ready, taken, defined, addr_ok, addr_rsv, lvi;
   logic [7:0] opcode;
   logic [15:0] fetch_addr;
   logic [1:0] length;
   logic [3:0] cycles;
   int n_fail = 0;
   int n_checks = 0;
   opcode_timing_and_program_map opcode_timing_and_program_map_i (
      .CLK_IN(clk_in), .RST_IN(rst_in), .FETCH_VALID_IN(fetch_valid),
      .OPCODE_IN(opcode), .FETCH_ADDR_IN(fetch_addr), .READY_OUT(ready),
      .TAKEN_OUT(taken), .LENGTH_OUT(length), .CYCLES_OUT(cycles),
      .DEFINED_OUT(defined), .ADDR_OK_OUT(addr_ok),
      .ADDR_RESERVED_OUT(addr_rsv), .LVI_RESET_OUT(lvi));
   program_store_model program_store_model_i (
      .clk(clk_in), .ready(ready), .fetch_valid(fetch_valid),
      .opcode(opcode), .fetch_addr(fetch_addr));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One fetch; a zero cycle figure skips the decode checks
   task automatic run(input logic [15:0] a, input logic [1:0] el, input logic [3:0] ec,
                      input logic ed);
      int n;
      program_store_model_i.fetch(a);
      @(negedge clk_in);
      check(taken, 1'b1, "taken");
      check(lvi, 1'b0, "supply reset");
      check(addr_ok, a >= USER_LO && a <= USER_HI && !(a >= TEST_LO && a <= TEST_HI), "ok");
      check(addr_rsv, a >= RSV_LO && a <= RSV_HI, "reserved");
      if (ec != 4'h0) begin
         check(length, el, "length");
         check(cycles, ec, "cycles");
         check(defined, ed, "defined");
      end
      n = 0;
      // Ready stays low for the opcode's cycles less one
      while (ready !== 1'b1 && n < 20) begin
         n++;
         @(negedge clk_in);
      end
      check(16'(n < 20), 16'h1, "ready never returned");
      if (n > 0) check(taken, 1'b0, "pulse width");
      if (ec != 4'h0) check(16'(n), 16'(ec - 4'h1), "spacing");
   endtask
   task automatic columns();
      for (int c = 0; c < 16; c++) begin
         if (c == 8) continue;
         run({8'h01, c[3:0], (c == 9) ? 4'h7 : 4'h0}, COL_LEN[c], COL_CYC[c], 1'b1);
      end
   endtask
   task automatic overrides();
      run(16'h0180, 2'h1, 4'h9, 1'b1);
      run(16'h0181, 2'h1, 4'h6, 1'b1);
      run(16'h0183, 2'h1, 4'hB, 1'b1);
      run(16'h01AD, 2'h2, 4'h8, 1'b1);
   endtask
   task automatic adjustments();
      for (int c = 11; c < 16; c++) begin
         run({8'h01, c[3:0], 4'h7}, COL_LEN[c], COL_CYC[c] + 4'h1, 1'b1);
         run({8'h01, c[3:0], 4'hF}, COL_LEN[c], COL_CYC[c] + 4'h1, 1'b1);
         run({8'h01, c[3:0], 4'hC}, COL_LEN[c], COL_CYC[c] - 4'h1, 1'b1);
         run({8'h01, c[3:0], 4'hD}, COL_LEN[c], COL_CYC[c] + 4'h3, 1'b1);
      end
   endtask
   // Empty map slots retire as one byte, one cycle, back to back
   task automatic undefined();
      logic [15:0] tbl [5] = '{16'h0131, 16'h0182, 16'h0190, 16'h01A7, 16'h01AF};
      foreach (tbl[i]) run(tbl[i], 2'h1, 4'h1, 1'b0);
   endtask
   // Window edges of the program store
   task automatic addresses();
      logic [15:0] tbl [10] = '{16'h007F, 16'h0080, 16'h0F79, 16'h0F7A, 16'h0FF1,
                                16'h0FF2, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000};
      foreach (tbl[i]) run(tbl[i], 2'h0, 4'h0, 1'b0);
   endtask
   // A fetch offered while a long opcode still counts waits for ready
   task automatic refused();
      time t0;
      program_store_model_i.fetch(16'h0100);
      t0 = $time;
      program_store_model_i.fetch(16'h0120);
      check(16'(($time - t0) / 4), 16'hA, "refused spacing");
      @(negedge clk_in);
      check(taken, 1'b1, "late take");
      check(cycles, COL_CYC[2], "late cycles");
      repeat (4) @(negedge clk_in);
      check(ready, 1'b1, "ready after late take");
   endtask
   // Reset in the middle of a long opcode, then resume
   task automatic reset_mid();
      program_store_model_i.fetch(16'h0100);
      @(posedge clk_in);
      rst_in <= 1'b1;
      @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      check(ready, 1'b1, "reset ready");
      check({taken, length, cycles}, 7'h00, "reset outputs");
      check(lvi, 1'b0, "reset supply");
      run(16'h0120, 2'h2, 4'h4, 1'b1);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      rst_in = 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      check(ready, 1'b1, "ready after reset");
      columns();
      overrides();
      adjustments();
      undefined();
      addresses();
      refused();
      reset_mid();
      summarize();
   end
   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #40000;
      n_fail++;
      summarize();
   end
endmodule

// >>> verif/program_store_model.sv
// Program store model: socketed memory that offers opcode fetches.
// Assumes the device takes a fetch at a rising edge with ready high.
`timescale 1ns/100ps
module program_store_model (
   input wire logic clk,
   input wire logic ready,
   output logic fetch_valid,
   output logic [7:0] opcode,
   output logic [15:0] fetch_addr
);
   // Code image: a user byte equals its address low byte
   function automatic logic [7:0] image(input logic [15:0] a);
      if (a >= 16'h1000 && a <= 16'h1FFF) begin
         return ~a[7:0]; // Unusable space, nothing kept there
      end
      if (a >= 16'h0F7A && a <= 16'h0FF1) begin
         return 8'hFF; // Self-test hole left blank
      end
      return a[7:0];
   endfunction
   initial begin
      fetch_valid = 1'b0;
      opcode = 8'h00;
      fetch_addr = 16'h0000;
   end
   // Offer one fetch and hold it until the device takes it
   task automatic fetch(input logic [15:0] a);
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      opcode <= image(a);
      do @(posedge clk); while (ready !== 1'b1);
      fetch_valid <= 1'b0;
      opcode <= ~image(a); // Released bus must not show a stale byte
   endtask
endmodule

// >>> verilog/decode_if.sv
// Interface between the timing sequencer and the opcode column decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/100ps
interface decode_if;
   import opcode_map_pkg::*;
   logic [OPC_W-1:0] opcode;
   logic [LEN_W-1:0] length;
   logic [CYC_W-1:0] cycles;
   logic defined;
   modport requester (output opcode, input length, cycles, defined);
   modport decoder (input opcode, output length, cycles, defined);
endinterface

// >>> verilog/opcode_column_decode.sv
// Combinational opcode decoder: bytes, cycles and defined flag per opcode.
// Assumes the requester registers the answer; no state is held here.
`timescale 1ns/100ps
module opcode_column_decode (
   decode_if.decoder dec
);
   import opcode_map_pkg::*;

   logic [3:0] col;
   logic [3:0] row;
   logic [3:0] cyc;

   // Column from the high nibble, row from the low nibble
   assign col = dec.opcode[7:4];
   assign row = dec.opcode[3:0];

   // Column figures, then the listed overrides and adjustments
   always_comb begin
      cyc = COL_CYC[col];
      if (dec.opcode == OPC_RET_INT) begin
         cyc = CYC_RET_INT;
      end else if (dec.opcode == OPC_RET_SUB) begin
         cyc = CYC_RET_SUB;
      end else if (dec.opcode == OPC_SW_INT) begin
         cyc = CYC_SW_INT;
      end else if (dec.opcode == OPC_BR_SUB) begin
         cyc = CYC_BR_SUB;
      end else if (col >= COL_MEM_FIRST) begin
         case (row)
            ROW_STORE_ACC, ROW_STORE_IDX: cyc = COL_CYC[col] + ADJ_STORE;
            ROW_JUMP: cyc = COL_CYC[col] - ADJ_JUMP;
            ROW_JUMP_SUB: cyc = COL_CYC[col] + ADJ_JUMP_SUB;
            default: cyc = COL_CYC[col];
         endcase
      end
      // Undefined slots get a harmless one-cycle figure
      dec.defined = COL_DEF[col][row];
      dec.length = dec.defined ? COL_LEN[col] : UNDEF_LEN;
      dec.cycles = dec.defined ? cyc : UNDEF_CYC;
   end

endmodule

// >>> verilog/opcode_map_pkg.sv
// Opcode map constants: column lengths and cycle counts, exceptions,
// per-column defined-opcode masks and the program address windows.
// Assumes an 8-bit opcode and a 16-bit program address.
package opcode_map_pkg;

   localparam int OPC_W = 8;
   localparam int ADDR_W = 16;
   localparam int LEN_W = 2;
   localparam int CYC_W = 4;
   localparam int NIB_W = 4;

   // Column codes (high nibble of the opcode)
   localparam logic [3:0] COL_BIT_TEST = 4'h0;
   localparam logic [3:0] COL_BIT_SET = 4'h1;
   localparam logic [3:0] COL_BRANCH = 4'h2;
   localparam logic [3:0] COL_INHERENT = 4'h8;
   localparam logic [3:0] COL_MEM_FIRST = 4'hB;

   // Row codes (low nibble) that carry a cycle adjustment in memory columns
   localparam logic [3:0] ROW_STORE_ACC = 4'h7;
   localparam logic [3:0] ROW_STORE_IDX = 4'hF;
   localparam logic [3:0] ROW_JUMP = 4'hC;
   localparam logic [3:0] ROW_JUMP_SUB = 4'hD;

   // Column bytes and cycles, indexed by the high nibble
   localparam logic [1:0] COL_LEN [16] = '{
      2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1,
      2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
   localparam logic [3:0] COL_CYC [16] = '{
      4'hA, 4'h7, 4'h4, 4'h6, 4'h4, 4'h4, 4'h7, 4'h6,
      4'h0, 4'h2, 4'h2, 4'h4, 4'h5, 4'h6, 4'h5, 4'h4};
   // Bit n set when row n of the column holds a defined opcode
   localparam logic [15:0] COL_DEF [16] = '{
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hB7D9, 16'hB7D9, 16'hB7D9, 16'hB7D9, 16'hB7D9,
      16'h000B, 16'hBF80, 16'h6F7F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

   // Opcodes whose cycle count overrides the column figure
   localparam logic [7:0] OPC_RET_INT = 8'h80;
   localparam logic [7:0] OPC_RET_SUB = 8'h81;
   localparam logic [7:0] OPC_SW_INT = 8'h83;
   localparam logic [7:0] OPC_BR_SUB = 8'hAD;
   localparam logic [3:0] CYC_RET_INT = 4'h9;
   localparam logic [3:0] CYC_RET_SUB = 4'h6;
   localparam logic [3:0] CYC_SW_INT = 4'hB;
   localparam logic [3:0] CYC_BR_SUB = 4'h8;

   // Parenthesised adjustments
   localparam logic [3:0] ADJ_STORE = 4'h1;
   localparam logic [3:0] ADJ_JUMP = 4'h1;
   localparam logic [3:0] ADJ_JUMP_SUB = 4'h3;

   // Undefined opcodes are retired as one-byte, one-cycle slots
   localparam logic [1:0] UNDEF_LEN = 2'h1;
   localparam logic [3:0] UNDEF_CYC = 4'h1;
   localparam logic [3:0] CYC_ONE = 4'h1;

   // Program address windows
   localparam logic [15:0] USER_LO = 16'h0080;
   localparam logic [15:0] USER_HI = 16'h0FFF;
   localparam logic [15:0] RSV_LO = 16'h1000;
   localparam logic [15:0] RSV_HI = 16'h1FFF;
   localparam logic [15:0] TEST_LO = 16'h0F7A;
   localparam logic [15:0] TEST_HI = 16'h0FF1;

endpackage

// >>> verilog/opcode_timing_and_program_map.sv
// Opcode timing sequencer and program address checker.
// Assumes fetches arrive synchronous to CLK_IN and are only taken while
// READY_OUT is high; the program store sits outside the device.
`timescale 1ns/100ps
module opcode_timing_and_program_map (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic FETCH_VALID_IN,
   input wire logic [opcode_map_pkg::OPC_W-1:0] OPCODE_IN,
   input wire logic [opcode_map_pkg::ADDR_W-1:0] FETCH_ADDR_IN,
   output logic READY_OUT,
   output logic TAKEN_OUT,
   output logic [opcode_map_pkg::LEN_W-1:0] LENGTH_OUT,
   output logic [opcode_map_pkg::CYC_W-1:0] CYCLES_OUT,
   output logic DEFINED_OUT,
   output logic ADDR_OK_OUT,
   output logic ADDR_RESERVED_OUT,
   output logic LVI_RESET_OUT
);
   import opcode_map_pkg::*;

   // Inclusive window test, used for each address range
   function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   decode_if dec ();

   opcode_column_decode u_decode (
      .dec(dec)
   );

   logic accept;
   logic [CYC_W-1:0] remain;
   logic [CYC_W-1:0] next_remain;
   logic next_ready;
   logic next_taken;
   logic [LEN_W-1:0] next_length;
   logic [CYC_W-1:0] next_cycles;
   logic next_defined;
   logic next_addr_ok;
   logic next_reserved;

   assign dec.opcode = OPCODE_IN;
   assign accept = FETCH_VALID_IN && READY_OUT;

   // Next values: hold the decoded figures until the next accepted fetch,
   // and count the instruction's cycles so the next fetch waits for it
   always_comb begin
      next_remain = remain;
      next_length = LENGTH_OUT;
      next_cycles = CYCLES_OUT;
      next_defined = DEFINED_OUT;
      next_addr_ok = ADDR_OK_OUT;
      next_reserved = ADDR_RESERVED_OUT;
      next_taken = accept;
      if (accept) begin
         next_length = dec.length;
         next_cycles = dec.cycles;
         next_defined = dec.defined;
         next_remain = dec.cycles - CYC_ONE;
         // Fetches outside the user window or inside self-test space are flagged
         next_addr_ok = in_range(FETCH_ADDR_IN, USER_LO, USER_HI) &&
                        !in_range(FETCH_ADDR_IN, TEST_LO, TEST_HI);
         next_reserved = in_range(FETCH_ADDR_IN, RSV_LO, RSV_HI);
      end else if (remain != '0) begin
         next_remain = remain - CYC_ONE;
      end
      next_ready = (next_remain == '0);
   end

   // Registers; READY comes up out of reset so the first fetch is immediate
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         remain <= '0;
         READY_OUT <= 1'b1;
         TAKEN_OUT <= 1'b0;
         LENGTH_OUT <= '0;
         CYCLES_OUT <= '0;
         DEFINED_OUT <= 1'b0;
         ADDR_OK_OUT <= 1'b0;
         ADDR_RESERVED_OUT <= 1'b0;
         LVI_RESET_OUT <= 1'b0;
      end else begin
         remain <= next_remain;
         READY_OUT <= next_ready;
         TAKEN_OUT <= next_taken;
         LENGTH_OUT <= next_length;
         CYCLES_OUT <= next_cycles;
         DEFINED_OUT <= next_defined;
         ADDR_OK_OUT <= next_addr_ok;
         ADDR_RESERVED_OUT <= next_reserved;
         // No voltage monitor exists, so this reset request never rises
         LVI_RESET_OUT <= 1'b0;
      end
   end

   // Length of the current not-ready stretch; lets a check compare the
   // fetch spacing against the cycle figure without trusting the counter
   logic [CYC_W-1:0] low_run;
   logic [CYC_W-1:0] next_low_run;

   always_comb begin
      next_low_run = '0;
      if (!READY_OUT) begin
         next_low_run = low_run + CYC_ONE;
      end
   end

   // Registers for the spacing helper
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         low_run <= '0;
      end else begin
         low_run <= next_low_run;
      end
   end

   // Checks on the decoded timing and address flags
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   bit_test_len_a: assert property (
      accept && OPCODE_IN[7:4] == COL_BIT_TEST |=> LENGTH_OUT == 2'h3 && CYCLES_OUT == 4'hA)
      else $error("bit test column timing wrong");

   bit_set_len_a: assert property (
      accept && OPCODE_IN[7:4] == COL_BIT_SET |=> LENGTH_OUT == 2'h2 && CYCLES_OUT == 4'h7)
      else $error("bit set column timing wrong");

   branch_wait_a: assert property (
      accept && OPCODE_IN[7:4] == COL_BRANCH |=> CYCLES_OUT == 4'h4 && !READY_OUT [*3]
      ##1 READY_OUT)
      else $error("branch did not hold fetch for four cycles");

   override_cycles_a: assert property (
      accept |=> ($past(OPCODE_IN) != 8'h80 || CYCLES_OUT == 4'h9)
      && ($past(OPCODE_IN) != 8'h81 || CYCLES_OUT == 4'h6)
      && ($past(OPCODE_IN) != 8'h83 || CYCLES_OUT == 4'hB)
      && ($past(OPCODE_IN) != 8'hAD || CYCLES_OUT == 4'h8))
      else $error("override cycle count wrong");

   adjust_cycles_a: assert property (
      accept |=> ($past(OPCODE_IN) != 8'hC7 || CYCLES_OUT == 4'h6)
      && ($past(OPCODE_IN) != 8'hBF || CYCLES_OUT == 4'h5)
      && ($past(OPCODE_IN) != 8'hCC || CYCLES_OUT == 4'h4)
      && ($past(OPCODE_IN) != 8'hDD || CYCLES_OUT == 4'h9))
      else $error("adjusted cycle count wrong");

   store_jump_a: assert property (
      accept |=> ($past(OPCODE_IN) != 8'hEF || CYCLES_OUT == 4'h6)
      && ($past(OPCODE_IN) != 8'hB7 || CYCLES_OUT == 4'h5)
      && ($past(OPCODE_IN) != 8'hBC || CYCLES_OUT == 4'h3)
      && ($past(OPCODE_IN) != 8'hFD || CYCLES_OUT == 4'h7))
      else $error("store or jump cycle count wrong");

   branch_sub_len_a: assert property (
      accept && OPCODE_IN == 8'hAD |=> LENGTH_OUT == 2'h2 && CYCLES_OUT == 4'h8)
      else $error("branch to subroutine timing wrong");

   take_answer_a: assert property (
      accept |=> TAKEN_OUT)
      else $error("taken fetch not answered");

   taken_pulse_a: assert property (
      TAKEN_OUT |-> $past(accept))
      else $error("taken pulse without a fetch");

   refused_fetch_a: assert property (
      FETCH_VALID_IN && !READY_OUT |=> !TAKEN_OUT)
      else $error("fetch taken while busy");

   figures_hold_a: assert property (
      !accept |=> $stable(LENGTH_OUT) && $stable(CYCLES_OUT) && $stable(DEFINED_OUT))
      else $error("decoded figures changed without a fetch");

   // The spacing between takes must follow the cycle figure just shown
   ready_span_a: assert property (
      !READY_OUT ##1 READY_OUT |-> low_run == CYCLES_OUT - CYC_ONE)
      else $error("fetch spacing differs from cycle count");

   undefined_len_a: assert property (
      accept && (OPCODE_IN == 8'h82 || OPCODE_IN == 8'h90 || OPCODE_IN == 8'hAF)
      |=> !DEFINED_OUT && LENGTH_OUT == 2'h1)
      else $error("undefined opcode length wrong");

   undefined_flag_a: assert property (
      accept && (OPCODE_IN == 8'h31 || OPCODE_IN == 8'hA7) |=> !DEFINED_OUT
      && CYCLES_OUT == 4'h1 && READY_OUT)
      else $error("undefined opcode not flagged");

   user_window_a: assert property (
      accept && (FETCH_ADDR_IN < 16'h0080 || FETCH_ADDR_IN > 16'h0FFF) |=> !ADDR_OK_OUT)
      else $error("fetch outside user window accepted");

   user_inside_a: assert property (
      accept && FETCH_ADDR_IN >= 16'h0080 && FETCH_ADDR_IN < 16'h0F7A |=> ADDR_OK_OUT)
      else $error("fetch inside user window flagged");

   selftest_addr_a: assert property (
      accept && FETCH_ADDR_IN >= 16'h0F7A && FETCH_ADDR_IN <= 16'h0FF1 |=> !ADDR_OK_OUT)
      else $error("self-test address accepted");

   reserved_addr_a: assert property (
      accept |=> ADDR_RESERVED_OUT == ($past(FETCH_ADDR_IN[15:12]) == 4'h1))
      else $error("reserved range flag wrong");

   no_lvi_a: assert property (
      !LVI_RESET_OUT)
      else $error("supply-drop reset raised");

   soft_int_seen_c: cover property (accept && OPCODE_IN == 8'h83 ##1 TAKEN_OUT);
   refused_c: cover property (FETCH_VALID_IN && !READY_OUT);
   undef_seen_c: cover property (accept && !dec.defined);
   back_to_back_c: cover property (accept ##1 accept);
   selftest_seen_c: cover property (TAKEN_OUT && !ADDR_OK_OUT);

endmodule
